/* hdl/flash_status_write_guard.v */
// Command interpreter for the status and protection logic of a serial flash.
// Assumes a mode 0 serial host on asynchronous pins, oversampled by clk.
`timescale 1ns/1ps
`default_nettype none
`include "flash_guard_defines.vh"
module flash_status_write_guard #(
  parameter [`TIMER_WIDTH-1:0] STATUS_WRITE_CYCLES = `STATUS_WRITE_CYCLES,
  parameter [`TIMER_WIDTH-1:0] ARRAY_OP_CYCLES = `ARRAY_OP_CYCLES,
  parameter [7:0] MAKER_ID = 8'h5A,
  parameter [7:0] DEVICE_ID = 8'h3C,
  parameter FACTORY_LOCKED = 1'b0
) (
  input wire clk,
  input wire rst_n,
  input wire cs_n_pin,
  input wire sclk_pin,
  input wire si_pin,
  input wire wp_n_pin,
  output reg so_q,
  output reg so_oe_q,
  output reg busy_q,
  output reg secured_area_q,
  output reg lock_down_q
);
  // MAKER_ID and DEVICE_ID defaults are arbitrary values.

  wire [3:0] pins_s;
  wire cs_n_s;
  wire sclk_s;
  wire si_s;
  wire wp_n_s;

  pin_sync #(
    .WIDTH(4),
    .RESET_VALUE(4'h9)
  ) u_pin_sync (
    .clk(clk),
    .rst_n(rst_n),
    .pin_in({cs_n_pin, sclk_pin, si_pin, wp_n_pin}),
    .pin_sync_out(pins_s)
  );

  assign cs_n_s = pins_s[3];
  assign sclk_s = pins_s[2];
  assign si_s = pins_s[1];
  assign wp_n_s = pins_s[0];

  reg cs_n_d_q;
  reg sclk_d_q;
  reg [6:0] rx_q;
  reg [2:0] bit_cnt_q;
  reg [2:0] byte_cnt_q;
  reg [7:0] op_q;
  reg [`ADDR_WIDTH-1:0] addr_q;
  reg [7:0] data_q;
  reg [7:0] tx_q;
  reg reply_q;
  reg id_sel_q;
  reg wel_q;
  reg status_write_disable_q;
  reg [3:0] prot_q;
  reg [4:0] new_status_q;
  reg status_job_q;
  reg timer_start_q;
  reg [`TIMER_WIDTH-1:0] timer_cycles_q;

  wire timer_done;

  busy_timer u_busy_timer (
    .clk(clk),
    .rst_n(rst_n),
    .start(timer_start_q),
    .cycles(timer_cycles_q),
    .done_q(timer_done)
  );

  wire sclk_rise = ~cs_n_s & sclk_s & ~sclk_d_q;
  wire sclk_fall = ~cs_n_s & ~sclk_s & sclk_d_q;
  wire cs_rise = cs_n_s & ~cs_n_d_q;
  wire [7:0] rx_byte = {rx_q, si_s};
  wire byte_done = sclk_rise & (bit_cnt_q == 3'h7);
  wire [7:0] cur_op = (byte_cnt_q == 3'h0) ? rx_byte : op_q;
  wire [2:0] next_byte = (byte_cnt_q == 3'h7) ? 3'h7 : byte_cnt_q + 3'h1;
  wire on_boundary = (bit_cnt_q == 3'h0);
  wire hw_protected = status_write_disable_q & ~wp_n_s;

  wire [7:0] status_byte;
  assign status_byte[`ST_STATUS_WRITE_DISABLE] = status_write_disable_q;
  assign status_byte[`ST_ZERO] = 1'b0;
  assign status_byte[`ST_PROT_HI:`ST_PROT_LO] = prot_q;
  assign status_byte[`ST_WEL] = wel_q;
  assign status_byte[`ST_BUSY] = busy_q;

  wire [7:0] security_byte;
  assign security_byte[7:2] = 6'h00;
  assign security_byte[`SEC_LOCK_DOWN] = lock_down_q;
  assign security_byte[`SEC_FACTORY_LOCK] = FACTORY_LOCKED;

  // Protect level N shields the top 2^(N-1) of 64 blocks; level 7 and up is everything.
  wire [6:0] first_prot_block = (prot_q >= 4'h7) ? 7'h00 :
    (`ARRAY_BLOCKS - (7'h01 << (prot_q - 4'h1)));
  wire addr_protected = (prot_q != 4'h0) &&
    ({1'b0, addr_q[21:16]} >= first_prot_block);

  wire is_block_erase = (op_q == `OP_BLOCK_ERASE_A) || (op_q == `OP_BLOCK_ERASE_B);
  wire is_chip_erase = (op_q == `OP_CHIP_ERASE_A) || (op_q == `OP_CHIP_ERASE_B);
  wire array_cmd_ok =
    ((op_q == `OP_PAGE_PROGRAM) && (byte_cnt_q >= 3'h5) && !addr_protected) ||
    (((op_q == `OP_SECTOR_ERASE) || is_block_erase) && (byte_cnt_q == 3'h4) &&
      !addr_protected) ||
    (is_chip_erase && (byte_cnt_q == 3'h1) && (prot_q == 4'h0));

  // Receive path, reply selection and serial output.
  always @(posedge clk or negedge rst_n) begin
    if (!rst_n) begin
      cs_n_d_q <= 1'b1;
      sclk_d_q <= 1'b0;
      rx_q <= 7'h00;
      bit_cnt_q <= 3'h0;
      byte_cnt_q <= 3'h0;
      op_q <= 8'h00;
      addr_q <= {`ADDR_WIDTH{1'b0}};
      data_q <= 8'h00;
      tx_q <= 8'h00;
      reply_q <= 1'b0;
      id_sel_q <= 1'b0;
      so_q <= 1'b0;
      so_oe_q <= 1'b0;
    end else begin
      cs_n_d_q <= cs_n_s;
      sclk_d_q <= sclk_s;
      if (cs_n_s) begin
        bit_cnt_q <= 3'h0;
        byte_cnt_q <= 3'h0;
        reply_q <= 1'b0;
        so_oe_q <= 1'b0;
        so_q <= 1'b0;
      end else if (sclk_rise) begin
        rx_q <= rx_byte[6:0];
        bit_cnt_q <= bit_cnt_q + 3'h1;
        if (byte_done) begin
          byte_cnt_q <= next_byte;
          if (byte_cnt_q == 3'h0) begin
            op_q <= rx_byte;
          end
          if ((byte_cnt_q >= 3'h1) && (byte_cnt_q <= 3'h3)) begin
            addr_q <= {addr_q[`ADDR_WIDTH-9:0], rx_byte};
          end
          if (byte_cnt_q == 3'h1) begin
            data_q <= rx_byte;
          end
          reply_q <= 1'b0;
          if (cur_op == `OP_READ_STATUS) begin
            tx_q <= status_byte;
            reply_q <= 1'b1;
          end else if (!busy_q && (cur_op == `OP_READ_SECURITY)) begin
            tx_q <= security_byte;
            reply_q <= 1'b1;
          end else if (!busy_q && (cur_op == `OP_READ_MAKER_DEVICE_ID)) begin
            if (byte_cnt_q == 3'h3) begin
              id_sel_q <= rx_byte[0];
              tx_q <= rx_byte[0] ? DEVICE_ID : MAKER_ID;
              reply_q <= 1'b1;
            end else if (byte_cnt_q >= 3'h4) begin
              id_sel_q <= ~id_sel_q;
              tx_q <= id_sel_q ? MAKER_ID : DEVICE_ID;
              reply_q <= 1'b1;
            end
          end
        end
      end else if (sclk_fall) begin
        so_oe_q <= reply_q;
        if (reply_q) begin
          so_q <= tx_q[7];
          tx_q <= {tx_q[6:0], 1'b0};
        end
      end
    end
  end

  // Command execution at deselect, and completion of timed cycles.
  always @(posedge clk or negedge rst_n) begin
    if (!rst_n) begin
      wel_q <= 1'b0;
      busy_q <= 1'b0;
      status_write_disable_q <= `RST_STATUS_WRITE_DISABLE;
      prot_q <= `RST_PROTECT_LEVEL;
      new_status_q <= 5'h00;
      status_job_q <= 1'b0;
      timer_start_q <= 1'b0;
      timer_cycles_q <= {`TIMER_WIDTH{1'b0}};
      secured_area_q <= 1'b0;
      lock_down_q <= 1'b0;
    end else begin
      timer_start_q <= 1'b0;
      if (timer_done) begin
        busy_q <= 1'b0;
        wel_q <= 1'b0;
        if (status_job_q) begin
          status_write_disable_q <= new_status_q[4];
          prot_q <= new_status_q[3:0];
        end
        status_job_q <= 1'b0;
      end else if (cs_rise && !busy_q && on_boundary) begin
        case (op_q)
          `OP_WRITE_ENABLE: begin
            if (byte_cnt_q == 3'h1) begin
              wel_q <= 1'b1;
            end
          end
          `OP_WRITE_DISABLE: begin
            if (byte_cnt_q == 3'h1) begin
              wel_q <= 1'b0;
            end
          end
          `OP_WRITE_STATUS: begin
            if ((byte_cnt_q == 3'h2) && wel_q && !hw_protected) begin
              new_status_q <= {data_q[`ST_STATUS_WRITE_DISABLE], data_q[`ST_PROT_HI:`ST_PROT_LO]};
              status_job_q <= 1'b1;
              busy_q <= 1'b1;
              timer_cycles_q <= STATUS_WRITE_CYCLES;
              timer_start_q <= 1'b1;
            end
          end
          `OP_WRITE_SECURITY: begin
            if (byte_cnt_q == 3'h1) begin
              lock_down_q <= 1'b1;
            end
          end
          `OP_ENTER_SECURED_AREA: begin
            if (byte_cnt_q == 3'h1) begin
              secured_area_q <= 1'b1;
            end
          end
          `OP_EXIT_SECURED_AREA: begin
            if (byte_cnt_q == 3'h1) begin
              secured_area_q <= 1'b0;
            end
          end
          default: begin
            if (wel_q && array_cmd_ok) begin
              busy_q <= 1'b1;
              timer_cycles_q <= ARRAY_OP_CYCLES;
              timer_start_q <= 1'b1;
            end
          end
        endcase
      end
    end
  end
endmodule
`default_nettype wire

/* hdl/flash_guard_defines.vh */
// Constants shared by the serial flash status and protection logic.
// Assumes inclusion by bare name from the design files.
`ifndef FLASH_GUARD_DEFINES_VH
`define FLASH_GUARD_DEFINES_VH

`define CLK_PERIOD_NS 8
`define STATUS_WRITE_TIME_NS 40000
`define ARRAY_OP_TIME_NS 8000
`define STATUS_WRITE_CYCLES ((`STATUS_WRITE_TIME_NS + `CLK_PERIOD_NS - 1) / `CLK_PERIOD_NS)
`define ARRAY_OP_CYCLES ((`ARRAY_OP_TIME_NS + `CLK_PERIOD_NS - 1) / `CLK_PERIOD_NS)
`define TIMER_WIDTH 24

`define OP_WRITE_ENABLE 8'h06
`define OP_WRITE_DISABLE 8'h04
`define OP_WRITE_STATUS 8'h01
`define OP_READ_STATUS 8'h05
`define OP_PAGE_PROGRAM 8'h02
`define OP_SECTOR_ERASE 8'h20
`define OP_BLOCK_ERASE_A 8'h52
`define OP_BLOCK_ERASE_B 8'hD8
`define OP_CHIP_ERASE_A 8'h60
`define OP_CHIP_ERASE_B 8'hC7
`define OP_READ_MAKER_DEVICE_ID 8'h90
`define OP_READ_SECURITY 8'h2B
`define OP_WRITE_SECURITY 8'h2F
`define OP_ENTER_SECURED_AREA 8'hB1
`define OP_EXIT_SECURED_AREA 8'hC1

`define ST_BUSY 0
`define ST_WEL 1
`define ST_PROT_LO 2
`define ST_PROT_HI 5
`define ST_ZERO 6
`define ST_STATUS_WRITE_DISABLE 7

`define SEC_FACTORY_LOCK 0
`define SEC_LOCK_DOWN 1

`define RST_PROTECT_LEVEL 4'h0
`define RST_STATUS_WRITE_DISABLE 1'b0
`define ADDR_WIDTH 24
`define ARRAY_BLOCKS 7'h40

`endif

/* hdl/pin_sync.v */
// Two-stage synchroniser for a group of asynchronous pin inputs.
// Assumes the pins are unrelated to clk; each bit is synchronised alone.
`timescale 1ns/1ps
`default_nettype none
module pin_sync #(
  parameter WIDTH = 4,
  parameter [WIDTH-1:0] RESET_VALUE = {WIDTH{1'b0}}
) (
  input wire clk,
  input wire rst_n,
  input wire [WIDTH-1:0] pin_in,
  output wire [WIDTH-1:0] pin_sync_out
);
  genvar i;
  generate
    for (i = 0; i < WIDTH; i = i + 1) begin : g_bit
      reg meta_q;
      reg stable_q;
      always @(posedge clk or negedge rst_n) begin
        if (!rst_n) begin
          meta_q <= RESET_VALUE[i];
          stable_q <= RESET_VALUE[i];
        end else begin
          meta_q <= pin_in[i];
          stable_q <= meta_q;
        end
      end
      assign pin_sync_out[i] = stable_q;
    end
  endgenerate
endmodule
`default_nettype wire

/* hdl/busy_timer.v */
// Down counter that times one self-timed internal cycle.
// Assumes start is a one-cycle pulse given only while the timer is idle.
`timescale 1ns/1ps
`default_nettype none
`include "flash_guard_defines.vh"
module busy_timer (
  input wire clk,
  input wire rst_n,
  input wire start,
  input wire [`TIMER_WIDTH-1:0] cycles,
  output reg done_q
);
  reg [`TIMER_WIDTH-1:0] count_q;
  reg running_q;

  always @(posedge clk or negedge rst_n) begin
    if (!rst_n) begin
      count_q <= {`TIMER_WIDTH{1'b0}};
      running_q <= 1'b0;
      done_q <= 1'b0;
    end else begin
      done_q <= 1'b0;
      if (start) begin
        count_q <= cycles;
        running_q <= 1'b1;
      end else if (running_q) begin
        if (count_q <= {{(`TIMER_WIDTH-1){1'b0}}, 1'b1}) begin
          running_q <= 1'b0;
          done_q <= 1'b1;
        end else begin
          count_q <= count_q - {{(`TIMER_WIDTH-1){1'b0}}, 1'b1};
        end
      end
    end
  end
endmodule
`default_nettype wire

/* tb/guard_checker.sv */
// Port assertions for the serial flash status and protection guard.
// Assumes one clock domain; bound to the guard by the statement at the foot.
`timescale 1ns/1ps
`default_nettype none
module guard_checker #(
  parameter int SWC = 8,
  parameter int AOC = 8
) (
  input wire logic clk,
  input wire logic rst_n,
  input wire logic cs_n_pin,
  input wire logic so_oe_q,
  input wire logic busy_q,
  input wire logic secured_area_q,
  input wire logic lock_down_q
);
  localparam int LO = SWC < AOC ? SWC : AOC;
  localparam int HI = SWC < AOC ? AOC : SWC;
  logic [23:0] busy_cnt_q;
  always_ff @(posedge clk or negedge rst_n) begin
    if (!rst_n) begin
      busy_cnt_q <= 24'h0;
    end else begin
      busy_cnt_q <= busy_q ? busy_cnt_q + 24'h1 : 24'h0;
    end
  end
  default clocking @(posedge clk); endclocking
  default disable iff (!rst_n);
  sequence cs_idle5;
    cs_n_pin [*5];
  endsequence
  sequence just_deselected;
    $past(cs_n_pin);
  endsequence
  a_lock_sticky: assert property (lock_down_q |=> lock_down_q)
    else $error("lock-down bit fell");
  a_lock_at_deselect: assert property ($rose(lock_down_q) |-> just_deselected)
    else $error("lock-down set while selected");
  a_area_at_deselect: assert property ($changed(secured_area_q) |-> just_deselected)
    else $error("secured area changed while selected");
  a_busy_at_deselect: assert property ($rose(busy_q) |-> just_deselected)
    else $error("busy rose while selected");
  a_busy_min_len: assert property ($fell(busy_q) |-> busy_cnt_q >= LO)
    else $error("busy cycle too short");
  a_busy_max_len: assert property (busy_cnt_q <= HI + 2)
    else $error("busy cycle too long");
  a_oe_off_idle: assert property (cs_idle5 |-> !so_oe_q)
    else $error("output driven while deselected");
  a_oe_on_select: assert property ($rose(so_oe_q) |-> !$past(cs_n_pin, 3))
    else $error("output enabled without select");
endmodule
bind flash_status_write_guard guard_checker #(.SWC(STATUS_WRITE_CYCLES), .AOC(ARRAY_OP_CYCLES))
  guard_chk (.clk(clk), .rst_n(rst_n), .cs_n_pin(cs_n_pin), .so_oe_q(so_oe_q),
  .busy_q(busy_q), .secured_area_q(secured_area_q), .lock_down_q(lock_down_q));
`default_nettype wire

/* tb/serial_host_model.sv */
// Behavioural mode 0 serial host that frames command bytes for the guard.
// Assumes clk is the system clock; pins move 1 ns after its rising edge.
`timescale 1ns/1ps
`default_nettype none
module serial_host_model (
  input wire logic clk,
  input wire logic so_q,
  input wire logic so_oe_q,
  output logic cs_n,
  output logic sclk,
  output logic si
);
  initial begin
    cs_n = 1'b1;
    sclk = 1'b0;
    si = 1'b0;
  end
  // Half a serial clock is five clk cycles, above the oversampling floor.
  task automatic half();
    repeat (5) @(posedge clk);
    #1;
  endtask
  task automatic sel();
    cs_n = 1'b0;
    half();
  endtask
  task automatic shift(input logic [7:0] tx, input int n, output logic [7:0] rx);
    rx = 8'h00;
    for (int i = 7; i >= 8 - n; i--) begin
      si = tx[i];
      half();
      sclk = 1'b1;
      rx[i] = so_oe_q ? so_q : 1'bx;
      half();
      sclk = 1'b0;
    end
  endtask
  task automatic desel();
    half();
    cs_n = 1'b1;
    si = ~si;
    repeat (4) half();
  endtask
endmodule
`default_nettype wire

/* tb/flash_status_write_guard_tb.sv */
// Self-checking bench for the serial flash status and protection guard.
// Assumes the host model frames every command; timed cycles are shortened.
`timescale 1ns/1ps
`default_nettype none
module flash_status_write_guard_tb;
  // Long enough that a full status poll fits inside one status write cycle.
  localparam logic [23:0] SWC = 24'h7D0;
  localparam logic [23:0] AOC = 24'h64;
  localparam logic [7:0] MAKER = 8'hA5; // Arbitrary value.
  localparam logic [7:0] DEVICE = 8'h17; // Arbitrary value.
  logic clk;
  logic rst_n;
  logic wp_n;
  wire cs_n, sclk, si, so, so_oe, busy, area, lock;
  int fail_count;
  int compares;
  logic [7:0] rx;
  logic [7:0] st;
  flash_status_write_guard #(.STATUS_WRITE_CYCLES(SWC), .ARRAY_OP_CYCLES(AOC),
    .MAKER_ID(MAKER), .DEVICE_ID(DEVICE)) uut (.clk(clk), .rst_n(rst_n),
    .cs_n_pin(cs_n), .sclk_pin(sclk), .si_pin(si), .wp_n_pin(wp_n), .so_q(so),
    .so_oe_q(so_oe), .busy_q(busy), .secured_area_q(area), .lock_down_q(lock));
  serial_host_model host (.clk(clk), .so_q(so), .so_oe_q(so_oe), .cs_n(cs_n),
    .sclk(sclk), .si(si));
  task automatic close_out();
    $display("compares %0d fail_count %0d", compares, fail_count);
    if (fail_count == 0 && compares > 0)
      $display("NO MISMATCHES");
    else
      $display("MISMATCHES SEEN");
    $finish;
  endtask
  task automatic chk(input string what, input logic [7:0] exp, input logic [7:0] got);
    compares++;
    if (got !== exp) begin
      fail_count++;
      $display("Error %s expected %h seen %h", what, exp, got);
    end
  endtask
  // The last byte of a frame may be cut short to n bits.
  task automatic send(input logic [7:0] b [$], input int n = 8);
    host.sel();
    foreach (b[i]) host.shift(b[i], (i == b.size() - 1) ? n : 8, rx);
    host.desel();
  endtask
  task automatic status();
    logic [7:0] again;
    send('{8'h05, 8'h00});
    st = rx;
    send('{8'h05, 8'h00, 8'h00});
    again = rx;
    host.sel();
    host.shift(8'h05, 8, rx);
    host.shift(8'h00, 8, st);
    host.shift(8'h00, 8, again);
    host.desel();
    chk("status repeat", st, again);
  endtask
  task automatic wait_idle();
    int n;
    n = 0;
    while (busy === 1'b1 && n < 4000) begin
      @(posedge clk);
      #1;
      n++;
    end
    chk("busy end", 8'h00, {7'h00, busy});
  endtask
  initial begin
    clk = 1'b0;
    forever #4 clk = ~clk;
  end
  initial begin
    #800000;
    fail_count++;
    close_out();
  end
  initial begin
    fail_count = 0;
    compares = 0;
    rst_n = 1'b0;
    wp_n = 1'b1;
    repeat (8) @(posedge clk);
    #1;
    rst_n = 1'b1;
    repeat (4) @(posedge clk);
    #1;
    status();
    chk("reset status", 8'h00, st);
    send('{8'h06});
    status();
    chk("latch set", 8'h02, st);
    send('{8'h04});
    status();
    chk("latch clear", 8'h00, st);
    send('{8'h01, 8'hFF});
    status();
    chk("write no latch", 8'h00, st);
    $display("test latch finished");
    send('{8'h06});
    send('{8'h01, 8'hFF});
    chk("busy started", 8'h01, {7'h00, busy});
    status();
    chk("status busy", 8'h03, st);
    wait_idle();
    status();
    chk("status written", 8'hBC, st);
    wp_n = 1'b0;
    send('{8'h06});
    send('{8'h01, 8'h00});
    status();
    chk("locked status", 8'hBC, st & 8'hFD);
    wp_n = 1'b1;
    send('{8'h06});
    send('{8'h01, 8'h04});
    wait_idle();
    status();
    chk("unlocked write", 8'h04, st);
    send('{8'h06});
    send('{8'h01, 8'h00}, 4);
    status();
    chk("partial frame", 8'h06, st);
    $display("test status write finished");
    send('{8'h20, 8'h3F, 8'h00, 8'h00});
    status();
    chk("protected erase", 8'h06, st);
    send('{8'h60});
    status();
    chk("chip erase", 8'h06, st);
    send('{8'h20, 8'h00, 8'h00, 8'h00});
    chk("erase busy", 8'h01, {7'h00, busy});
    wait_idle();
    status();
    chk("erase done", 8'h04, st);
    $display("test protect level finished");
    send('{8'h2B, 8'h00});
    chk("security", 8'h00, rx);
    send('{8'h2F});
    send('{8'h2B, 8'h00});
    chk("security locked", 8'h02, rx);
    chk("lock pin", 8'h01, {7'h00, lock});
    send('{8'hB1});
    chk("area enter", 8'h01, {7'h00, area});
    send('{8'hC1});
    chk("area exit", 8'h00, {7'h00, area});
    for (int a = 0; a < 2; a++) begin
      send('{8'h90, 8'h00, 8'h00, 8'(a), 8'h00});
      chk("first id", a ? DEVICE : MAKER, rx);
      send('{8'h90, 8'h00, 8'h00, 8'(a), 8'h00, 8'h00});
      chk("second id", a ? MAKER : DEVICE, rx);
    end
    $display("test security finished");
    close_out();
  end
endmodule
`default_nettype wire
